// ---- usp_top.sv ----
// serial port with synchronous mode 0 and asynchronous modes 1 to 3 behind a wishbone slave
//
// Summary of operation
// - a finished byte is moved to a holding buffer; shifting in the next proceeds.
// - overrun flags when a new byte lands while the previous is still unread.
// - one data address: reads give the receive buffer, writes load transmit.
// - tx done is control bit 1, rx done is control bit 0.
// - done flags clear only by software writes, never by hardware.
// - mode 0 is synchronous, clock divided by 12, eight bits, no framing.
// - mode 1 is 8 data bits, start and stop, timer overflow baud.
// - mode 2 is 9 data bits, start and stop, clock divided by 32 or 64.
// - mode 3 is 9 data bits, start and stop, timer overflow baud.
// - mode 0 data is half duplex on the data pin, clock on the other.
// - mode 0 the port always drives the shift clock; the peer never does.
// - mode 0 a data write sends eight bits lsb first; tx done after bit eight.
// - mode 0 reception starts when receive enable is 1 and rx done is 0.
// - mode 0 rx done sets one cycle after bit eight; reception then waits.
// - an interrupt is requested when enabled and either done flag is set.
// - mode 0 the data pin is only ever pulled low, open drain.
// - async receive loads only if rx done is 0 and check bit rules pass.
// - async tx done sets at the start of the stop bit.
// - nine-bit modes send the tx ninth bit and store the received ninth bit.
// - mode 2 uses clock/32 with the doubler set, clock/64 otherwise.
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "usp_map.svh"
`default_nettype none

module usp_top (
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // baud sources from timer overflows
    input  wire logic        tx_baud_tick_i,
    input  wire logic        rx_baud_tick_i,
    // serial_data_pin, open drain in mode 0
    input  wire logic        serial_data_pin_i,
    output logic             serial_data_pin_o,
    output logic             serial_data_pin_oe_n_o,
    // shift_clock_pin: mode 0 clock, async transmit line
    output logic             shift_clock_pin_o,
    // interrupt request
    output logic             irq_o
);

    // control and status state
    logic [1:0] mode;
    logic       multiproc_check_bit;
    logic       rx_enable_bit;
    logic       tx_ninth_bit;
    logic       rx_ninth_bit;
    logic       tx_done_flag;
    logic       rx_done_flag;
    logic       baud_doubler_bit;
    logic       overrun_flag;
    logic       irq_enable;
    logic       unread;
    logic [7:0] serial_data_buffer;
    logic [1:0] div_cnt;

    // engines
    usp_pkg::usp_tx_state_t tx_st;
    usp_pkg::usp_rx_state_t rx_st;
    logic [10:0] tx_sh;
    logic [3:0]  tx_cnt;
    logic [3:0]  tx_idx;
    logic [8:0]  rx_sh;
    logic [3:0]  rx_cnt;
    logic [3:0]  rx_idx;
    logic        rx_stop;

    // bus decode
    wire        acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr      = acc & wb_we_i & wb_sel_i[0];
    wire        hit_ctl = wb_adr_i == `USP_OFF_CTRL;
    wire        hit_dat = wb_adr_i == `USP_OFF_DATA;
    wire        hit_aux = wb_adr_i == `USP_OFF_AUX;
    wire        ctrl_we = wr & hit_ctl;
    wire        data_we = wr & hit_dat;
    wire        data_rd = acc & ~wb_we_i & hit_dat;
    wire        aux_we  = wr & hit_aux;
    wire [7:0]  wd      = wb_dat_i[7:0];

    // read mux
    wire [7:0]  ctrl_rd = {mode, multiproc_check_bit, rx_enable_bit,
                           tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
    wire [2:0]  aux_rd  = {irq_enable, overrun_flag, baud_doubler_bit};
    wire [31:0] rd_mux  = hit_ctl ? {24'h0, ctrl_rd} :
                          hit_dat ? {24'h0, serial_data_buffer} :
                          hit_aux ? {29'h0, aux_rd} : 32'h0;

    // mode decode
    wire m0   = mode == `USP_MODE0;
    wire m1   = mode == `USP_MODE1;
    wire m2   = mode == `USP_MODE2;

    // fixed mode 2 baud, 16 ticks per bit
    // doubler picks every 2nd or every 4th clock for a tick
    wire m2_tick  = baud_doubler_bit ? div_cnt[0] : (div_cnt == 2'h3);
    // mode 1 and 3 ticks come from timer overflows
    // same timer source for nine-bit mode 3
    wire tx_tick  = m2 ? m2_tick : tx_baud_tick_i;
    wire rx_tick  = m2 ? m2_tick : rx_baud_tick_i;

    // transmit timing
    wire tx_run   = tx_st == usp_pkg::USP_TX_RUN;
    wire rx_run   = rx_st == usp_pkg::USP_RX_RUN;
    // mode 0 steps every clock, twelve per bit
    wire tx_adv   = m0 | tx_tick;
    wire [3:0] tx_len  = m0 ? `USP_M0_LAST : `USP_OS_LAST;
    wire [3:0] tx_last = m0 ? `USP_IDX_M0 : (m1 ? `USP_IDX_8BIT : `USP_IDX_9BIT);
    wire tx_bend  = tx_run & tx_adv & (tx_cnt == tx_len);
    wire tx_fin   = tx_bend & (tx_idx == tx_last);
    // half duplex, no transmit while a mode 0 receive runs
    wire tx_start = data_we & ~tx_run & ~(m0 & rx_run);
    // tx done after the eighth mode 0 bit
    // async tx done as the stop bit begins
    wire ti_set   = m0 ? tx_fin : (tx_bend & (tx_idx == tx_last - 4'h1));
    // ninth bit from tx_ninth_bit, frame lsb first after a start bit
    wire [10:0] tx_load = m0 ? {3'h7, wd} : {1'b1, (m1 ? 1'b1 : tx_ninth_bit), wd, 1'b0};

    // receive timing
    wire rx_adv   = m0 | rx_tick;
    wire [3:0] rx_len  = m0 ? `USP_M0_LAST : `USP_OS_LAST;
    wire [3:0] rx_smpc = m0 ? `USP_M0_LAST : `USP_OS_MID;
    wire [3:0] rx_last = m0 ? `USP_IDX_M0 : (m1 ? `USP_IDX_8BIT : `USP_IDX_9BIT);
    wire rx_smp   = rx_run & rx_adv & (rx_cnt == rx_smpc);
    wire rx_bend  = rx_run & rx_adv & (rx_cnt == rx_len);
    wire rx_lastb = rx_idx == rx_last;
    wire rx_false = ~m0 & (rx_idx == 4'h0) & serial_data_pin_i;
    wire rx_shift = m0 | ((rx_idx != 4'h0) & ~rx_lastb);
    // mode 0 reception needs enable set and rx done clear
    // held off while rx done stays set
    wire rx_m0_go = m0 & rx_enable_bit & ~rx_done_flag & ~tx_run & ~data_we;
    wire rx_as_go = ~m0 & rx_enable_bit & ~serial_data_pin_i;
    wire rx_start = (rx_st == usp_pkg::USP_RX_IDLE) & (rx_m0_go | rx_as_go);
    wire rx_evt   = rx_st == usp_pkg::USP_RX_DONE;
    wire [7:0] rx_byte = (m0 | m1) ? rx_sh[8:1] : rx_sh[7:0];
    wire rx_nine  = m1 ? rx_stop : rx_sh[8];
    // load only with rx done clear and the check bit satisfied
    wire rx_ok    = ~rx_done_flag & (m0 | ~multiproc_check_bit | rx_nine);
    wire load     = rx_evt & rx_ok;
    // overrun when a byte lands on an unread one
    wire ovr_set  = load & unread;

    // pin drive
    wire m0_tx    = m0 & tx_run;
    wire m0_rx    = m0 & rx_run;
    // mode 0 clock always generated here
    // clock idles high, low half then high half per bit
    wire next_sclk = m0 ? (m0_tx ? (tx_cnt >= `USP_M0_HALF) :
                           m0_rx ? (rx_cnt >= `USP_M0_HALF) : 1'b1) : tx_sh[0];
    // data pin only pulled low in mode 0
    wire next_oe_n = ~(m0_tx & ~tx_sh[0]);
    // request while enabled and a done flag is set
    wire next_irq  = irq_enable & (tx_done_flag | rx_done_flag);

    // bus answer: one cycle after the strobe, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= acc;
            if (acc) begin
                wb_dat_o <= rd_mux;
            end
        end
    end

    // control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {mode, multiproc_check_bit, rx_enable_bit, tx_ninth_bit} <= 5'h00;
        end else if (ctrl_we) begin
            mode                <= wd[`USP_CTRL_MODE_HI:`USP_CTRL_MODE_LO];
            multiproc_check_bit <= wd[`USP_CTRL_MPCHK];
            rx_enable_bit       <= wd[`USP_CTRL_RXEN];
            tx_ninth_bit        <= wd[`USP_CTRL_TX9];
        end
    end

    // done flags: hardware set beats a software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_done_flag <= 1'b0;
            rx_done_flag <= 1'b0;
        end else begin
            // tx done in bit 1, rx done in bit 0
            // only a software write clears either flag
            tx_done_flag <= ti_set | (ctrl_we ? wd[`USP_CTRL_TXDONE] : tx_done_flag);
            rx_done_flag <= load | (ctrl_we ? wd[`USP_CTRL_RXDONE] : rx_done_flag);
        end
    end

    // receive holding buffer and ninth bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_data_buffer <= 8'h00;
            rx_ninth_bit       <= 1'b0;
        end else if (load) begin
            // completed byte parked apart from the shifter
            serial_data_buffer <= rx_byte;
            // received ninth bit (stop bit in mode 1)
            rx_ninth_bit       <= m0 ? rx_ninth_bit : rx_nine;
        end else if (ctrl_we) begin
            rx_ninth_bit       <= wd[`USP_CTRL_RX9];
        end
    end

    // auxiliary register, unread tracking and overrun
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {irq_enable, overrun_flag, baud_doubler_bit} <= `USP_AUX_RESET;
            unread <= 1'b0;
        end else begin
            if (aux_we) begin
                baud_doubler_bit <= wd[`USP_AUX_DOUBLER];
                irq_enable       <= wd[`USP_AUX_IRQEN];
            end
            // sticky until software clears, storage goes ahead
            overrun_flag <= ovr_set | (aux_we ? wd[`USP_AUX_OVERRUN] : overrun_flag);
            unread       <= load | (unread & ~data_rd);
        end
    end

    // free divider for the mode 2 tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= 2'h0;
        end else begin
            div_cnt <= div_cnt + 2'h1;
        end
    end

    // transmit engine, shared by mode 0 and the async modes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_st  <= usp_pkg::USP_TX_IDLE;
            tx_sh  <= 11'h7FF;
            tx_cnt <= 4'h0;
            tx_idx <= 4'h0;
        end else begin
            case (tx_st)
                usp_pkg::USP_TX_IDLE: begin
                    // a data write launches the frame
                    if (tx_start) begin
                        tx_sh  <= tx_load;
                        tx_cnt <= 4'h0;
                        tx_idx <= 4'h0;
                        tx_st  <= usp_pkg::USP_TX_RUN;
                    end
                end
                usp_pkg::USP_TX_RUN: begin
                    if (tx_adv) begin
                        if (tx_cnt == tx_len) begin
                            // bit changes only at the period boundary
                            tx_cnt <= 4'h0;
                            tx_sh  <= {1'b1, tx_sh[10:1]};
                            tx_idx <= tx_idx + 4'h1;
                            if (tx_fin) begin
                                tx_st <= usp_pkg::USP_TX_IDLE;
                            end
                        end else begin
                            tx_cnt <= tx_cnt + 4'h1;
                        end
                    end
                end
                default: begin
                    tx_st <= usp_pkg::USP_TX_IDLE;
                end
            endcase
        end
    end

    // receive engine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_st   <= usp_pkg::USP_RX_IDLE;
            rx_sh   <= 9'h000;
            rx_cnt  <= 4'h0;
            rx_idx  <= 4'h0;
            rx_stop <= 1'b0;
        end else begin
            case (rx_st)
                usp_pkg::USP_RX_IDLE: begin
                    if (rx_start) begin
                        rx_cnt <= 4'h0;
                        rx_idx <= 4'h0;
                        rx_st  <= usp_pkg::USP_RX_RUN;
                    end
                end
                usp_pkg::USP_RX_RUN: begin
                    if (rx_smp & rx_false) begin
                        // start bit gone high again: glitch, drop it
                        rx_st <= usp_pkg::USP_RX_IDLE;
                    end else if (rx_smp & rx_lastb) begin
                        // rx done follows one cycle after the last sample (the stop bit in the async modes)
                        if (m0) begin
                            rx_sh <= {serial_data_pin_i, rx_sh[8:1]};
                        end
                        rx_stop <= serial_data_pin_i;
                        rx_st   <= usp_pkg::USP_RX_DONE;
                    end else begin
                        if (rx_smp & rx_shift) begin
                            rx_sh <= {serial_data_pin_i, rx_sh[8:1]};
                        end
                        if (rx_adv) begin
                            rx_cnt <= rx_bend ? 4'h0 : rx_cnt + 4'h1;
                        end
                        if (rx_bend) begin
                            rx_idx <= rx_idx + 4'h1;
                        end
                    end
                end
                usp_pkg::USP_RX_DONE: begin
                    rx_st <= usp_pkg::USP_RX_IDLE;
                end
                default: begin
                    rx_st <= usp_pkg::USP_RX_IDLE;
                end
            endcase
        end
    end

    // registered pins and interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_clock_pin_o      <= 1'b1;
            serial_data_pin_o      <= 1'b0;
            serial_data_pin_oe_n_o <= 1'b1;
            irq_o                  <= 1'b0;
        end else begin
            shift_clock_pin_o      <= next_sclk;
            serial_data_pin_o      <= 1'b0;
            serial_data_pin_oe_n_o <= next_oe_n;
            irq_o                  <= next_irq;
        end
    end

endmodule

`default_nettype wire

// ---- usp_map.svh ----
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef USP_MAP_SVH
`define USP_MAP_SVH

// register byte offsets on the bus
`define USP_OFF_CTRL      8'h00
`define USP_OFF_DATA      8'h04
`define USP_OFF_AUX       8'h08

// serial_control_reg fields
`define USP_CTRL_MODE_HI  7
`define USP_CTRL_MODE_LO  6
`define USP_CTRL_MPCHK    5
`define USP_CTRL_RXEN     4
`define USP_CTRL_TX9      3
`define USP_CTRL_RX9      2
`define USP_CTRL_TXDONE   1
`define USP_CTRL_RXDONE   0
`define USP_CTRL_RESET    8'h00

// serial_aux_status_reg fields
`define USP_AUX_DOUBLER   0
`define USP_AUX_OVERRUN   1
`define USP_AUX_IRQEN     2
`define USP_AUX_RESET     3'h0

// mode encodings
`define USP_MODE0         2'h0
`define USP_MODE1         2'h1
`define USP_MODE2         2'h2
`define USP_MODE3         2'h3

// mode 0: twelve system clocks per bit, clock low for the first six
`define USP_M0_LAST       4'hB
`define USP_M0_HALF       4'h6
// asynchronous modes: sixteen baud ticks per bit, sampled mid bit
`define USP_OS_LAST       4'hF
`define USP_OS_MID        4'h7
// last bit index of a frame
`define USP_IDX_M0        4'h7
`define USP_IDX_8BIT      4'h9
`define USP_IDX_9BIT      4'hA

`endif

// ---- usp_pkg.sv ----
// types shared by the serial port design
`default_nettype none

package usp_pkg;
    typedef enum logic [0:0] {
        USP_TX_IDLE,
        USP_TX_RUN
    } usp_tx_state_t;

    typedef enum logic [1:0] {
        USP_RX_IDLE,
        USP_RX_RUN,
        USP_RX_DONE
    } usp_rx_state_t;
endpackage

`default_nettype wire

// ---- usp_asserts.sv ----
// concurrent checks on the serial port's bus and pins
`timescale 1ns/100ps
`include "usp_map.svh"
`default_nettype none

module usp_asserts (
    // system
    input wire logic        clk_i,
    input wire logic        rst_i,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // pins
    input wire logic        serial_data_pin_o,
    input wire logic        serial_data_pin_oe_n_o,
    input wire logic        shift_clock_pin_o,
    input wire logic        irq_o
);
    logic [1:0] mode;
    // request taken, and writes that may clear flags
    wire taken    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_ctrl  = taken & wb_we_i & wb_sel_i[0] & (wb_adr_i == `USP_OFF_CTRL);
    wire wr_flags = wr_ctrl | (taken & wb_we_i & wb_sel_i[0] & (wb_adr_i == `USP_OFF_AUX));

    // mode field as software last wrote it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= `USP_MODE0;
        end else if (wr_ctrl) begin
            mode <= wb_dat_i[7:6];
        end
    end

    a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        taken |=> wb_ack_o) else $error("bus request not answered next cycle");
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_read_upper: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("read data upper bits set");
    a_open_drain: assert property (@(posedge clk_i) disable iff (rst_i)
        !serial_data_pin_o) else $error("data pin driven high");
    a_oe_mode_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        mode != `USP_MODE0 |-> serial_data_pin_oe_n_o) else $error("data pin driven outside mode 0");
    a_sck_low_half: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == `USP_MODE0) && $fell(shift_clock_pin_o) |-> !shift_clock_pin_o[*5] ##[1:2] shift_clock_pin_o)
        else $error("shift clock low phase wrong");
    a_sck_high_half: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == `USP_MODE0) && $rose(shift_clock_pin_o) |-> shift_clock_pin_o[*5])
        else $error("shift clock high phase short");
    // irq_o lags a software clear by one cycle, so the cycle after a write is excused too
    a_flags_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o && !wr_flags && !$past(wr_flags) |=> irq_o) else $error("done flag cleared by hardware");
endmodule

bind usp_top usp_asserts u_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .serial_data_pin_o(serial_data_pin_o),
    .serial_data_pin_oe_n_o(serial_data_pin_oe_n_o), .shift_clock_pin_o(shift_clock_pin_o), .irq_o(irq_o)
);
`default_nettype wire

// ---- usp_peer.sv ----
// far-side serial peer: mode 0 shift register and asynchronous partner
`timescale 1ns/100ps
`default_nettype none

module usp_peer (
    // clock and link
    input  wire logic clk_i,
    input  wire logic sck_i,
    input  wire logic line_i,
    output var  logic line_o
);
    logic [7:0] m0_out;
    logic [7:0] m0_cap;
    logic       m0_drive;
    int         m0_idx;

    initial begin
        line_o = 1'b1;
        m0_drive = 1'b0;
        m0_idx = 0;
        m0_cap = 8'h00;
    end
    // next bit follows the port's falling shift clock
    always @(negedge sck_i) begin
        if (m0_drive) begin
            line_o <= m0_out[m0_idx[2:0]];
            m0_idx <= m0_idx + 1;
        end
    end
    // capture on the rising shift clock, lsb first
    always @(posedge sck_i) begin
        m0_cap <= {line_i, m0_cap[7:1]};
    end
    // present a byte for mode 0 reception
    task automatic m0_load(input logic [7:0] b);
        m0_out = b;
        m0_idx = 0;
        m0_drive = 1'b1;
    endtask
    // release the line to the pull-up
    task automatic m0_stop();
        m0_drive = 1'b0;
        line_o <= 1'b1;
    endtask
    // start bit, data lsb first, stop bit
    task automatic send(input logic [8:0] d, input int nb, input int bc);
        for (int i = 0; i < nb + 2; i++) begin
            @(posedge clk_i);
            line_o <= (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : d[i - 1];
            repeat (bc - 1) @(posedge clk_i);
        end
    endtask
    // sample a frame mid bit; data then stop bit
    task automatic recv(input int nb, input int bc, output logic [9:0] v);
        v = 10'h000;
        @(negedge sck_i);
        repeat (bc / 2) @(posedge clk_i);
        for (int i = 0; i <= nb; i++) begin
            repeat (bc) @(posedge clk_i);
            v[i] = sck_i;
        end
    endtask
endmodule
`default_nettype wire

// ---- usp_top_tb_top.sv ----
// self-checking bench for the serial port
`timescale 1ns/100ps
`include "usp_map.svh"
`default_nettype none

module usp_top_tb_top;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tick;
    logic [7:0]  wb_adr_i, b1, b2;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        pin_o, pin_oe_n, sck, irq_o, peer_line, t9, r9, dbl, nb9;
    logic [1:0]  m;
    logic [9:0]  got;
    int          fails, total_checks, seed, bc;
    // open-drain data wire with pull-up
    wire         data_line = (pin_oe_n ? 1'b1 : pin_o) & peer_line;

    usp_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_baud_tick_i(tick), .rx_baud_tick_i(tick),
        .serial_data_pin_i(data_line), .serial_data_pin_o(pin_o), .serial_data_pin_oe_n_o(pin_oe_n),
        .shift_clock_pin_o(sck), .irq_o(irq_o));
    usp_peer peer (.clk_i(clk_i), .sck_i(sck), .line_i(data_line), .line_o(peer_line));

    // clock and baud ticks every second cycle
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        tick <= rst_i ? 1'b0 : ~tick;
    end
    // compare and count
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one classic wishbone cycle, read data left in rd
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        // ack is due one cycle after the request is taken
        check("bus ack cycles", 32'h2, n);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // poll a control bit under a bounded count
    task automatic wait_flag(input int b);
        int n;
        n = 0;
        do begin
            wb(1'b0, `USP_OFF_CTRL, 8'h00);
            n++;
        end while (rd[b] !== 1'b1 && n < 2000);
        check("done flag", 32'h1, {31'h0, rd[b]});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (60000) @(posedge clk_i);
        fails++;
        $display("wrong value watchdog expected finish seen timeout");
        summarize();
    end

    initial begin
        seed = 36;
        fails = 0;
        total_checks = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h00000000;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // reset values, unmapped address and idle pins
        wb(1'b0, `USP_OFF_CTRL, 8'h00);
        check("ctrl reset", 32'h0, rd);
        wb(1'b0, `USP_OFF_AUX, 8'h00);
        check("aux reset", 32'h0, rd);
        wb(1'b0, 8'h0C, 8'h00);
        check("unmapped read", 32'h0, rd);
        check("idle pins", 32'h3, {30'h0, sck, pin_oe_n});
        wb(1'b1, `USP_OFF_AUX, 8'h04);
        // mode 0 transmit of a random byte
        b1 = 8'($random(seed));
        wb(1'b1, `USP_OFF_DATA, b1);
        wait_flag(`USP_CTRL_TXDONE);
        check("mode 0 tx byte", {24'h000000, b1}, {24'h000000, peer.m0_cap});
        check("irq on tx done", 32'h1, {31'h0, irq_o});
        repeat (50) @(posedge clk_i);
        wb(1'b0, `USP_OFF_CTRL, 8'h00);
        check("flags held", 32'h02, rd);
        wb(1'b1, `USP_OFF_CTRL, 8'h00);
        check("irq after clear", 32'h0, {31'h0, irq_o});
        // mode 0 receive twice, first byte never read
        b1 = 8'($random(seed));
        b2 = 8'($random(seed));
        peer.m0_load(b1);
        wb(1'b1, `USP_OFF_CTRL, 8'h10);
        wait_flag(`USP_CTRL_RXDONE);
        peer.m0_load(b2);
        wb(1'b1, `USP_OFF_CTRL, 8'h10);
        wait_flag(`USP_CTRL_RXDONE);
        wb(1'b1, `USP_OFF_CTRL, 8'h00);
        peer.m0_stop();
        wb(1'b0, `USP_OFF_DATA, 8'h00);
        check("mode 0 rx newest", {24'h000000, b2}, rd);
        wb(1'b0, `USP_OFF_AUX, 8'h00);
        check("overrun", 32'h06, rd);
        // asynchronous modes 1, 2 doubled, 2 plain, 3
        for (int k = 0; k < 4; k++) begin
            m = (k == 0) ? 2'h1 : (k == 3) ? 2'h3 : 2'h2;
            dbl = (k != 2);
            bc = (m == 2'h2 && !dbl) ? 64 : 32;
            nb9 = (m != 2'h1);
            t9 = 1'($random(seed));
            r9 = 1'($random(seed));
            b1 = 8'($random(seed));
            b2 = 8'($random(seed));
            wb(1'b1, `USP_OFF_AUX, {7'h02, dbl});
            wb(1'b1, `USP_OFF_CTRL, {m, 2'b01, t9, 3'b000});
            fork
                peer.recv(nb9 ? 9 : 8, bc, got);
                wb(1'b1, `USP_OFF_DATA, b1);
            join
            check("tx done by stop bit", 32'h1, {31'h0, irq_o});
            check("async tx frame", {22'h0, nb9 ? {1'b1, t9, b1} : {2'b01, b1}}, {22'h0, got});
            peer.send({r9, b2}, nb9 ? 9 : 8, bc);
            wait_flag(`USP_CTRL_RXDONE);
            peer.send({~r9, ~b2}, nb9 ? 9 : 8, bc);
            wb(1'b0, `USP_OFF_CTRL, 8'h00);
            check("async ctrl", {24'h000000, m, 2'b01, t9, nb9 ? r9 : 1'b1, 2'b11}, rd);
            wb(1'b0, `USP_OFF_DATA, 8'h00);
            check("async rx kept", {24'h000000, b2}, rd);
        end
        // mode 3 with the check bit set: a frame with ninth bit 0 is dropped, one with 1 kept
        b1 = 8'($random(seed));
        wb(1'b1, `USP_OFF_CTRL, 8'hF0);
        peer.send({1'b0, b1}, 9, 32);
        peer.send({1'b1, ~b1}, 9, 32);
        wait_flag(`USP_CTRL_RXDONE);
        check("check bit ctrl", 32'h000000F5, rd);
        wb(1'b0, `USP_OFF_DATA, 8'h00);
        check("check bit filter", {24'h000000, ~b1}, rd);
        summarize();
    end
endmodule
`default_nettype wire
